// ==== hdl/bbf_host.sv ====
// Purpose: host controller driving a byte-wide boot block flash over its async bus
// Assumes: user inputs synchronous to ref_clk; one request at a time
// Notes: device-side rules listed for reference; host keeps R7-R11, R19
//
// Contract
// [R1] device holds 262144 bytes addressed by eighteen address lines
// [R2] device powers up in read mode, reading like a rom
// [R3] top boot map: 64K x3, 32K, 8K x2, 16K boot at top
// [R4] bottom boot map: 16K boot at zero, 8K x2, 32K, 64K x3
// [R5] each block erases alone, others unchanged
// [R6] device keeps per-block protection, refuses program/erase on protected blocks
// [R7] address selects read location or forms part of a write command
// [R8] device drives data on reads; host drives command byte on writes
// [R9] chip enable high makes device ignore all other pins
// [R10] output enable for reads, write enable for writes, one at a time
// [R11] host holds reset low minimum time, then waits longer recovery delay
// [R12] reset pin at high identification level unprotects all blocks
// [R13] variants without reset pin lack reset and unprotection
// [R14] unconnected reset pin acts as inactive high
// [R15] device ignores writes while supply below lockout level
// [R16] supply drop below lockout aborts running program or erase
// [R17] internal controller sequences program/erase; host sees completion and errors
// [R18] delivered array reads all ones
// [R19] read: address, chip and output enable low, write enable high
// [R20] write address captured on last falling edge of chip/write enable
// [R21] write data captured on first rising edge; output enable stays high
// [R22] invalid write sequence returns device to read mode
// [R23] hardware reset abandons partial commands, read mode after recovery
module bbf_host
    import bbf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic top_boot,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [BBF_ADDR_W-1:0] req_addr,
    input wire logic [BBF_DATA_W-1:0] req_wdata,
    input wire logic hw_reset_req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [BBF_DATA_W-1:0] rsp_rdata,
    output logic [BBF_BLK_W-1:0] rsp_block,
    output logic [BBF_ADDR_W-1:0] address_inputs,
    input wire logic [BBF_DATA_W-1:0] data_lines_in,
    output logic [BBF_DATA_W-1:0] data_lines_out,
    output logic data_lines_oe,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic reset_unprotect_pin_n
);
    // ****************************************
    // sequencer
    // ****************************************
    bbf_state_e state_reg;
    logic [BBF_CNT_W-1:0] cnt_reg;
    logic wr_reg;
    logic [BBF_BLK_W-1:0] blk_next;

    assign req_ready = (state_reg == BBF_IDLE) && !hw_reset_req;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= BBF_RST_PULSE;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                BBF_RST_PULSE: begin
                    if (cnt_reg == BBF_CNT_W'(BBF_RESET_PULSE_CYC - 1)) begin // [R11]
                        state_reg <= BBF_RST_RECOVER;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                BBF_RST_RECOVER: begin
                    if (cnt_reg == BBF_CNT_W'(BBF_RECOVERY_CYC - 1)) begin // [R11] [R23]
                        state_reg <= BBF_IDLE;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                BBF_IDLE: begin
                    cnt_reg <= '0;
                    if (hw_reset_req) begin
                        state_reg <= BBF_RST_PULSE;
                    end else if (req_valid) begin
                        state_reg <= req_write ? BBF_WR_SETUP : BBF_RD_ACCESS;
                    end
                end
                BBF_RD_ACCESS: begin
                    if (cnt_reg == BBF_CNT_W'(BBF_ACCESS_CYC)) begin // [R19]
                        state_reg <= BBF_IDLE;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                BBF_WR_SETUP: begin
                    if (cnt_reg == BBF_CNT_W'(BBF_SETUP_CYC - 1)) begin
                        state_reg <= BBF_WR_PULSE;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                BBF_WR_PULSE: begin
                    if (cnt_reg == BBF_CNT_W'(BBF_WRITE_CYC - 1)) begin // [R20] [R21]
                        state_reg <= BBF_WR_HOLD;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                BBF_WR_HOLD: begin
                    if (cnt_reg == BBF_CNT_W'(BBF_SETUP_CYC - 1)) begin
                        state_reg <= BBF_IDLE;
                        cnt_reg <= '0;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= BBF_RST_PULSE;
                    cnt_reg <= '0;
                end
            endcase
        end
    end

    // ****************************************
    // bus pins
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            address_inputs <= '0;
            data_lines_out <= '0;
            wr_reg <= 1'b0;
        end else if (state_reg == BBF_IDLE && req_valid && !hw_reset_req) begin
            address_inputs <= req_addr; // [R7]
            data_lines_out <= req_wdata; // [R8]
            wr_reg <= req_write;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            chip_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            data_lines_oe <= 1'b0;
            reset_unprotect_pin_n <= 1'b0;
        end else begin
            reset_unprotect_pin_n <= !(state_reg == BBF_RST_PULSE && cnt_reg != BBF_CNT_W'(BBF_RESET_PULSE_CYC - 1))
                && !(state_reg == BBF_IDLE && hw_reset_req); // [R11]
            case (state_reg)
                BBF_IDLE: begin
                    chip_enable_n <= !(req_valid && !hw_reset_req); // [R9]
                    output_enable_n <= !(req_valid && !hw_reset_req && !req_write); // [R10] [R19]
                    write_enable_n <= 1'b1;
                    data_lines_oe <= req_valid && !hw_reset_req && req_write; // [R8]
                end
                BBF_RD_ACCESS: begin
                    if (cnt_reg == BBF_CNT_W'(BBF_ACCESS_CYC)) begin
                        chip_enable_n <= 1'b1;
                        output_enable_n <= 1'b1;
                    end
                end
                BBF_WR_SETUP: begin
                    // write enable falls last: address latched here
                    write_enable_n <= !(cnt_reg == BBF_CNT_W'(BBF_SETUP_CYC - 1)); // [R20]
                end
                BBF_WR_PULSE: begin
                    // write enable rises first: data latched here
                    if (cnt_reg == BBF_CNT_W'(BBF_WRITE_CYC - 1)) begin
                        write_enable_n <= 1'b1; // [R21]
                    end
                end
                BBF_WR_HOLD: begin
                    if (cnt_reg == BBF_CNT_W'(BBF_SETUP_CYC - 1)) begin
                        chip_enable_n <= 1'b1;
                        data_lines_oe <= 1'b0;
                    end
                end
                default: begin
                    chip_enable_n <= 1'b1;
                    output_enable_n <= 1'b1;
                    write_enable_n <= 1'b1;
                    data_lines_oe <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // block decode of the request address
    // ****************************************
    always_comb begin
        blk_next = BBF_BLK0;
        if (top_boot) begin // [R3]
            if (address_inputs >= BBF_TOP_B6) blk_next = BBF_BLK6;
            else if (address_inputs >= BBF_TOP_B5) blk_next = BBF_BLK5;
            else if (address_inputs >= BBF_TOP_B4) blk_next = BBF_BLK4;
            else if (address_inputs >= BBF_TOP_B3) blk_next = BBF_BLK3;
            else if (address_inputs >= BBF_TOP_B2) blk_next = BBF_BLK2;
            else if (address_inputs >= BBF_TOP_B1) blk_next = BBF_BLK1;
        end else begin // [R4]
            if (address_inputs >= BBF_BOT_B6) blk_next = BBF_BLK6;
            else if (address_inputs >= BBF_BOT_B5) blk_next = BBF_BLK5;
            else if (address_inputs >= BBF_BOT_B4) blk_next = BBF_BLK4;
            else if (address_inputs >= BBF_BOT_B3) blk_next = BBF_BLK3;
            else if (address_inputs >= BBF_BOT_B2) blk_next = BBF_BLK2;
            else if (address_inputs >= BBF_BOT_B1) blk_next = BBF_BLK1;
        end
    end

    // ****************************************
    // response
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            rsp_block <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (state_reg == BBF_RD_ACCESS && cnt_reg == BBF_CNT_W'(BBF_ACCESS_CYC)) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= data_lines_in; // [R8] [R19]
                rsp_block <= blk_next;
            end else if (state_reg == BBF_WR_HOLD && cnt_reg == BBF_CNT_W'(BBF_SETUP_CYC - 1) && wr_reg) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= '0;
                rsp_block <= blk_next;
            end
        end
    end
endmodule : bbf_host

// ==== pkg/bbf_pkg.sv ====
// Purpose: constants for the boot block flash host port controller
// Assumes: 200 MHz ref_clk
// Notes: times in ns, counts derived from the clock period
package bbf_pkg;
    // ****************************************
    // bus geometry
    // ****************************************
    localparam int BBF_ADDR_W = 18;
    localparam int BBF_DATA_W = 8;
    localparam int BBF_NUM_BLOCKS = 7;
    localparam int BBF_BLK_W = 3;
    localparam logic [17:0] BBF_ADDR_LAST = 18'h3_ffff;
    localparam logic [7:0] BBF_ERASED_BYTE = 8'hff;
    // ****************************************
    // timing
    // ****************************************
    localparam int BBF_CLK_PERIOD_NS = 5;
    localparam int BBF_ACCESS_TIME_NS = 45;
    localparam int BBF_WRITE_PULSE_NS = 40;
    localparam int BBF_SETUP_NS = 10;
    localparam int BBF_RESET_PULSE_MIN_TIME_NS = 500;
    localparam int BBF_RESET_RECOVERY_TIME_A_NS = 50;
    localparam int BBF_RESET_RECOVERY_TIME_B_NS = 50;
    localparam int BBF_ACCESS_CYC = (BBF_ACCESS_TIME_NS + BBF_CLK_PERIOD_NS - 1) / BBF_CLK_PERIOD_NS;
    localparam int BBF_WRITE_CYC = (BBF_WRITE_PULSE_NS + BBF_CLK_PERIOD_NS - 1) / BBF_CLK_PERIOD_NS;
    localparam int BBF_SETUP_CYC = (BBF_SETUP_NS + BBF_CLK_PERIOD_NS - 1) / BBF_CLK_PERIOD_NS;
    localparam int BBF_RESET_PULSE_CYC =
        (BBF_RESET_PULSE_MIN_TIME_NS + BBF_CLK_PERIOD_NS - 1) / BBF_CLK_PERIOD_NS;
    localparam int BBF_REC_A_CYC = (BBF_RESET_RECOVERY_TIME_A_NS + BBF_CLK_PERIOD_NS - 1) / BBF_CLK_PERIOD_NS;
    localparam int BBF_REC_B_CYC = (BBF_RESET_RECOVERY_TIME_B_NS + BBF_CLK_PERIOD_NS - 1) / BBF_CLK_PERIOD_NS;
    localparam int BBF_RECOVERY_CYC = (BBF_REC_A_CYC > BBF_REC_B_CYC) ? BBF_REC_A_CYC : BBF_REC_B_CYC;
    localparam int BBF_CNT_W = 8;
    // ****************************************
    // block map boundaries
    // ****************************************
    localparam logic [17:0] BBF_TOP_B1 = 18'h1_0000;
    localparam logic [17:0] BBF_TOP_B2 = 18'h2_0000;
    localparam logic [17:0] BBF_TOP_B3 = 18'h3_0000;
    localparam logic [17:0] BBF_TOP_B4 = 18'h3_8000;
    localparam logic [17:0] BBF_TOP_B5 = 18'h3_a000;
    localparam logic [17:0] BBF_TOP_B6 = 18'h3_c000;
    localparam logic [17:0] BBF_BOT_B1 = 18'h0_4000;
    localparam logic [17:0] BBF_BOT_B2 = 18'h0_6000;
    localparam logic [17:0] BBF_BOT_B3 = 18'h0_8000;
    localparam logic [17:0] BBF_BOT_B4 = 18'h1_0000;
    localparam logic [17:0] BBF_BOT_B5 = 18'h2_0000;
    localparam logic [17:0] BBF_BOT_B6 = 18'h3_0000;
    localparam logic [2:0] BBF_BLK0 = 3'h0;
    localparam logic [2:0] BBF_BLK1 = 3'h1;
    localparam logic [2:0] BBF_BLK2 = 3'h2;
    localparam logic [2:0] BBF_BLK3 = 3'h3;
    localparam logic [2:0] BBF_BLK4 = 3'h4;
    localparam logic [2:0] BBF_BLK5 = 3'h5;
    localparam logic [2:0] BBF_BLK6 = 3'h6;
    // ****************************************
    // sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        BBF_RST_PULSE,
        BBF_RST_RECOVER,
        BBF_IDLE,
        BBF_RD_ACCESS,
        BBF_WR_SETUP,
        BBF_WR_PULSE,
        BBF_WR_HOLD
    } bbf_state_e;
endpackage : bbf_pkg

// ==== tb/bbf_flash_model.sv ====
// Purpose: behavioural byte-wide flash facing bbf_host
// Assumes: a bus write stores its byte directly, no command decoding
// Notes: undriven data lines show the inverse of the last byte read
module bbf_flash_model
    import bbf_pkg::*;
#(
    parameter int ACC_NS = 45
)
(
    input wire logic [BBF_ADDR_W-1:0] address_inputs,
    input wire logic [BBF_DATA_W-1:0] data_from_host,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic reset_unprotect_pin_n,
    output logic [BBF_DATA_W-1:0] data_to_host
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [BBF_DATA_W-1:0] mem [logic [BBF_ADDR_W-1:0]];
    logic [BBF_DATA_W-1:0] drv;
    logic [BBF_DATA_W-1:0] last = BBF_ERASED_BYTE;
    logic [BBF_ADDR_W-1:0] wa;
    logic wr_act = 1'b0;
    // reads like a rom, unwritten cells read all ones
    always @* begin
        if (!chip_enable_n && !output_enable_n && write_enable_n && reset_unprotect_pin_n) begin
            drv = mem.exists(address_inputs) ? mem[address_inputs] : BBF_ERASED_BYTE;
        end else begin
            drv = ~last;
        end
    end
    assign #(ACC_NS) data_to_host = drv;
    always @(posedge output_enable_n) last = data_to_host;
    // address on last falling strobe, data on first rising strobe
    always @(negedge chip_enable_n or negedge write_enable_n) begin
        if (!chip_enable_n && !write_enable_n && reset_unprotect_pin_n) begin
            wa = address_inputs;
            wr_act = 1'b1;
        end
    end
    always @(posedge chip_enable_n or posedge write_enable_n) begin
        if (wr_act && reset_unprotect_pin_n) begin
            mem[wa] = data_from_host;
        end
        wr_act = 1'b0;
    end
    always @(negedge reset_unprotect_pin_n) wr_act = 1'b0;
endmodule : bbf_flash_model

// ==== tb/bbf_host_properties.sv ====
// Purpose: bus protocol checks on the ports of bbf_host
// Assumes: single ref_clk domain, rstn async active low
// Notes: bound to bbf_host below the module
module bbf_host_props
    import bbf_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire logic req_write,
    input logic req_ready,
    input logic rsp_valid,
    input logic [BBF_ADDR_W-1:0] address_inputs,
    input logic [BBF_DATA_W-1:0] data_lines_out,
    input logic data_lines_oe,
    input logic chip_enable_n,
    input logic output_enable_n,
    input logic write_enable_n,
    input logic reset_unprotect_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic [7:0] low_cnt_reg;
    // cycles the reset pin has been low
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_reg <= 8'h00;
        end else if (reset_unprotect_pin_n) begin
            low_cnt_reg <= 8'h00;
        end else if (low_cnt_reg != 8'hff) begin
            low_cnt_reg <= low_cnt_reg + 8'h01;
        end
    end
    chk_reset_pulse_len: assert property (
        $rose(reset_unprotect_pin_n) |-> low_cnt_reg >= 8'(BBF_RESET_PULSE_CYC))
        else $error("reset pulse too short");
    chk_recovery_wait: assert property (
        $rose(reset_unprotect_pin_n) |-> !req_ready [*8] ##1 !req_ready ##1 !req_ready)
        else $error("request accepted during recovery");
    chk_read_walk: assert property (
        req_valid && req_ready && !req_write |=> (!chip_enable_n && !output_enable_n && write_enable_n) [*8]
        ##1 (!chip_enable_n && !output_enable_n) ##1 (!chip_enable_n && !output_enable_n)
        ##1 (rsp_valid && chip_enable_n && output_enable_n))
        else $error("read strobes or latency wrong");
    chk_write_walk: assert property (
        req_valid && req_ready && req_write |-> ##3 !write_enable_n [*8] ##1 write_enable_n
        ##1 !chip_enable_n ##1 (chip_enable_n && rsp_valid))
        else $error("write strobes or latency wrong");
    chk_oe_exclusive: assert property (
        !output_enable_n |-> !chip_enable_n && write_enable_n && !data_lines_oe)
        else $error("output enable without read framing");
    chk_we_frame: assert property (
        !write_enable_n |-> !chip_enable_n && output_enable_n && data_lines_oe
        && $stable(address_inputs) && $stable(data_lines_out))
        else $error("write pulse framing wrong");
    chk_idle_release: assert property (
        chip_enable_n |-> !data_lines_oe && output_enable_n && write_enable_n)
        else $error("bus active while deselected");
    chk_ready_idle: assert property (
        req_ready |-> chip_enable_n && reset_unprotect_pin_n)
        else $error("ready while bus or reset busy");
endmodule : bbf_host_props

bind bbf_host bbf_host_props chk (.ref_clk(ref_clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .address_inputs(address_inputs),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .chip_enable_n(chip_enable_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .reset_unprotect_pin_n(reset_unprotect_pin_n));

// ==== tb/test_boot_block_flash_bus_port.sv ====
// Purpose: self-checking bench for bbf_host against a flash model
// Assumes: inputs driven 1ns after the rising edge
// Notes: block map rows first, resets and refusals after
module test_boot_block_flash_bus_port import bbf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic top; logic wr; logic [17:0] a; logic [7:0] d; logic [2:0] blk;} bbf_row_s;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic top_boot = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [17:0] req_addr = 18'h0_0000;
    logic [7:0] req_wdata = 8'h00;
    logic hw_reset_req = 1'b0;
    logic req_ready, rsp_valid, data_lines_oe, chip_enable_n, output_enable_n, write_enable_n, rp_n;
    logic [7:0] rsp_rdata, data_lines_out, flash_dq, rd;
    logic [2:0] rsp_block, bk;
    logic [17:0] address_inputs;
    wire logic [7:0] dq = data_lines_oe ? data_lines_out : flash_dq;
    int fails = 0;
    int comparisons = 0;
    int n;
    bbf_row_s rows [18] = '{
        '{1, 0, 18'h3_ffff, 8'hff, 6}, '{1, 1, 18'h3_c000, 8'ha5, 6}, '{1, 0, 18'h3_c000, 8'ha5, 6},
        '{1, 0, 18'h3_bfff, 8'hff, 5}, '{1, 1, 18'h3_a000, 8'h5a, 5}, '{1, 0, 18'h3_a000, 8'h5a, 5},
        '{1, 0, 18'h3_9fff, 8'hff, 4}, '{1, 0, 18'h3_7fff, 8'hff, 3}, '{1, 0, 18'h2_ffff, 8'hff, 2},
        '{1, 0, 18'h1_0000, 8'hff, 1}, '{1, 0, 18'h0_ffff, 8'hff, 0}, '{0, 1, 18'h0_3fff, 8'h3c, 0},
        '{0, 0, 18'h0_3fff, 8'h3c, 0}, '{0, 0, 18'h0_4000, 8'hff, 1}, '{0, 0, 18'h0_6000, 8'hff, 2},
        '{0, 0, 18'h0_8000, 8'hff, 3}, '{0, 0, 18'h1_0000, 8'hff, 4}, '{0, 0, 18'h3_0000, 8'hff, 6}};
    bbf_host uut (.ref_clk(ref_clk), .rstn(rstn), .top_boot(top_boot), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .hw_reset_req(hw_reset_req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_block(rsp_block),
        .address_inputs(address_inputs), .data_lines_in(dq), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe), .chip_enable_n(chip_enable_n), .output_enable_n(output_enable_n),
        .write_enable_n(write_enable_n), .reset_unprotect_pin_n(rp_n));
    bbf_flash_model flash (.address_inputs(address_inputs), .data_from_host(dq), .chip_enable_n(chip_enable_n),
        .output_enable_n(output_enable_n), .write_enable_n(write_enable_n), .reset_unprotect_pin_n(rp_n),
        .data_to_host(flash_dq));
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wait_ready(output int k);
        k = 0;
        while (req_ready !== 1'b1 && k < 400) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        check("ready_timeout", 0, k >= 400);
    endtask : wait_ready
    task automatic do_req(input logic w, input logic [17:0] a, input logic [7:0] d);
        int k;
        wait_ready(k);
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(posedge ref_clk);
        #1;
        req_valid = 1'b0;
        for (k = 0; k < 40 && rsp_valid !== 1'b1; k++) begin
            @(posedge ref_clk);
            #1;
        end
        check("rsp_timeout", 0, k >= 40);
        rd = rsp_rdata;
        bk = rsp_block;
    endtask : do_req
    task automatic end_of_test;
        if (fails == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (10) @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        wait_ready(n);
        check("ready_delay", BBF_RESET_PULSE_CYC + BBF_RECOVERY_CYC, n);
        foreach (rows[i]) begin
            top_boot = rows[i].top;
            do_req(rows[i].wr, rows[i].a, rows[i].d);
            check("rsp_rdata", rows[i].wr ? 8'h00 : rows[i].d, rd);
            check("rsp_block", rows[i].blk, bk);
        end
        hw_reset_req = 1'b1;
        req_valid = 1'b1;
        req_write = 1'b1;
        req_addr = 18'h0_1234;
        req_wdata = 8'h77;
        @(posedge ref_clk);
        #1;
        hw_reset_req = 1'b0;
        repeat (50) @(posedge ref_clk);
        check("pin_during_hw_reset", 0, rp_n);
        check("ready_during_hw_reset", 0, req_ready);
        req_valid = 1'b0;
        wait_ready(n);
        check("hw_reset_len", BBF_RESET_PULSE_CYC + BBF_RECOVERY_CYC - 50, n);
        do_req(1'b0, 18'h0_1234, 8'h00);
        check("refused_write_absent", 8'hff, rd);
        req_valid = 1'b1;
        repeat (5) @(posedge ref_clk);
        #1;
        rstn = 1'b0;
        req_valid = 1'b0;
        #1;
        check("strobes_in_reset", 3'b111, {chip_enable_n, output_enable_n, write_enable_n});
        check("bus_released_in_reset", 2'b00, {data_lines_oe, rp_n});
        @(posedge ref_clk);
        #1;
        rstn = 1'b1;
        do_req(1'b0, 18'h3_c000, 8'h00);
        check("read_after_reset", 8'ha5, rd);
        end_of_test();
    end
    initial begin
        #20us;
        fails++;
        end_of_test();
    end
endmodule : test_boot_block_flash_bus_port
